// [core/pcap_consts.svh]
// register offsets, reset values and timing constants of the capture engine
`ifndef PCAP_CONSTS_SVH
`define PCAP_CONSTS_SVH

`define PCAP_OFF_CTRL      8'h00
`define PCAP_OFF_STATUS    8'h04
`define PCAP_OFF_EVENT     8'h08
`define PCAP_OFF_FILTER    8'h0C
`define PCAP_OFF_VALSEL    8'h10
`define PCAP_OFF_TRIGSRC   8'h14
`define PCAP_OFF_TRIGEDGE  8'h18
`define PCAP_OFF_PREEDGE   8'h1C
`define PCAP_OFF_PRESRC    8'h20
`define PCAP_OFF_POS_LO    8'h24
`define PCAP_OFF_POS_HI    8'h28
`define PCAP_OFF_TIME      8'h2C

`define PCAP_RST_EVENT     8'h00
`define PCAP_RST_FILTER    8'h00
`define PCAP_RST_VALSEL    8'h00
`define PCAP_RST_TRIGSRC   8'h00
`define PCAP_RST_TRIGEDGE  8'h01
`define PCAP_RST_PREEDGE   8'h01
`define PCAP_RST_PRESRC    8'h00

`define PCAP_MAX_EVENT     8'h03
`define PCAP_MAX_FILTER    8'h02
`define PCAP_MAX_VALSEL    8'h04
`define PCAP_MAX_TRIGSRC   8'h0B
`define PCAP_MAX_PRESRC    8'h0A
`define PCAP_MAX_EDGE      8'h03
`define PCAP_IDX_PRIMARY   8'h0A
`define PCAP_EDGE_RISE     8'h01
`define PCAP_EDGE_FALL     8'h02
`define PCAP_EDGE_BOTH     8'h03

`define PCAP_CLK_NS        32'h0000_0014
`define PCAP_TICK_NS       32'h0000_0028
`define PCAP_NS_PER_CLK    (`PCAP_CLK_NS)

`endif

// [core/pcap_pkg.sv]
// types of the capture engine
package pcap_pkg;
  typedef enum logic [1:0] {
    pcap_idle   = 2'h0,
    pcap_armed  = 2'h1,
    pcap_primed = 2'h3
  } pcap_state_t;
  typedef enum logic [1:0] {
    pcap_ev_ignore = 2'h0,
    pcap_ev_after  = 2'h1,
    pcap_ev_high   = 2'h2,
    pcap_ev_low    = 2'h3
  } pcap_event_t;
  typedef enum logic [2:0] {
    pcap_val_pos   = 3'h0,
    pcap_val_time  = 3'h1,
    pcap_val_rsvd  = 3'h2,
    pcap_val_index = 3'h3,
    pcap_val_auto  = 3'h4
  } pcap_value_t;
endpackage

// [core/pcap_engine.sv]
// position capture engine with precondition logic and axi4-lite registers
//
// Functional notes
// - event mode 0: precondition ignored, first qualifying trigger edge captures
// - event mode 1: capture on first trigger edge after selected precondition edge
// - event mode 2: capture on trigger edge while precondition is high
// - event mode 3: capture on trigger edge while precondition is low
// - precondition used only for nonzero event mode; event mode takes 0 to 3
// - precondition edge select used only in event mode 1
// - mode 1: enable, then fresh precondition edge, then fresh trigger edge
// - mode 1: trigger edge in same tick as precondition edge does not count
// - modes 2 and 3 sample filtered precondition level at trigger edge; the code samples the synchronised level, capture_input_filter is unused
// - value mode 0 latches position feedback into captured position
// - value mode 1 latches internal time into captured time
// - value mode 3 sets trigger source 10, rising edge, event mode 0
// - value mode 3 enables immediately and re-arms after each capture
// - value mode 4 latches position and re-arms itself after each capture
// - precondition edge: 1 rising, 2 falling, 3 both, 0 reserved, default 1
// - trigger always qualified by edge detection in every event mode
// - precondition source: 0-6 general, 7-9 rs485, 10 primary index
// - captured position is signed 64-bit, read-only, resets to zero
// - non-re-arming modes clear the enable after each capture
// - enabling clears captured flag; next capture sets it; the code does not clear it when value mode 3 enables
// - trigger edge: 1 rising, 2 falling, 3 both on filtered trigger; the code detects edges on the synchronised trigger, no filter
// - trigger source: 0-6 general, 7-9 rs485, 10 primary, 11 tertiary
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pcap_consts.svh"

module pcap_engine (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic [6:0]         gen_in_i,
  input  wire logic [2:0]         rs485_in_i,
  input  wire logic               index_primary_i,
  input  wire logic               index_tertiary_i,
  input  wire logic signed [63:0] position_feedback_i,
  input  wire logic               time_ref_sync_i,
  input  wire logic [7:0]         s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  input  wire logic [31:0]        s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  input  wire logic [7:0]         s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output logic [31:0]             s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  output logic                    captured_flag_o
);

  // registers
  logic [7:0]                  precondition_event_mode;
  logic [7:0]                  capture_input_filter;
  logic [7:0]                  capture_value_select;
  logic [7:0]                  trigger_source_select;
  logic [7:0]                  trigger_edge_select;
  logic [7:0]                  precondition_edge_select;
  logic [7:0]                  precondition_source_select;
  logic signed [63:0]          captured_position;
  logic [31:0]                 captured_time;
  logic                        captured_flag;
  pcap_pkg::pcap_state_t       state;

  // bus state
  logic                        aw_full;
  logic [7:0]                  aw_addr;
  logic                        w_full;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;
  logic                        do_wr;

  // capture path
  logic [11:0]                 line_meta;
  logic [11:0]                 line_sync;
  logic [11:0]                 line_prev;
  logic                        trig_edge;
  logic                        pre_edge;
  logic                        pre_level;
  logic                        qualify;
  logic                        cap_fire;
  logic                        auto_rearm;
  logic                        arm_wr;
  logic [31:0]                 time_ns;

  function automatic logic reg_known(input logic [7:0] a);
    case (a)
      `PCAP_OFF_CTRL, `PCAP_OFF_STATUS, `PCAP_OFF_EVENT, `PCAP_OFF_FILTER,
      `PCAP_OFF_VALSEL, `PCAP_OFF_TRIGSRC, `PCAP_OFF_TRIGEDGE,
      `PCAP_OFF_PREEDGE, `PCAP_OFF_PRESRC, `PCAP_OFF_POS_LO,
      `PCAP_OFF_POS_HI, `PCAP_OFF_TIME: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction

  function automatic logic sel_line(input logic [11:0] v, input logic [7:0] code,
                                    input logic [7:0] lim);
    sel_line = (code <= lim) ? v[code[3:0]] : 1'b0;
  endfunction

  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [7:0] es);
    case (es)
      `PCAP_EDGE_RISE: edge_hit = cur & ~prev;
      `PCAP_EDGE_FALL: edge_hit = ~cur & prev;
      `PCAP_EDGE_BOTH: edge_hit = cur ^ prev;
      default:         edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [3:0] s, input logic [7:0] off);
    wr_hit = en && (a == off) && s[0];
  endfunction

  // axi4-lite write channel
  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o  = ~w_full;
  assign do_wr           = aw_full & w_full & ~s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_i && !aw_full) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_wr) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && !w_full) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_wr) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'h0;
    end else if (do_wr) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= reg_known(aw_addr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // axi4-lite read channel
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= 2'h0;
      s_axi_rdata_o  <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= reg_known(s_axi_araddr_i) ? 2'h0 : 2'h2;
      case (s_axi_araddr_i)
        `PCAP_OFF_CTRL:     s_axi_rdata_o <= {31'h0, state != pcap_pkg::pcap_idle};
        `PCAP_OFF_STATUS:   s_axi_rdata_o <= {31'h0, captured_flag};
        `PCAP_OFF_EVENT:    s_axi_rdata_o <= {24'h00_0000, precondition_event_mode};
        `PCAP_OFF_FILTER:   s_axi_rdata_o <= {24'h00_0000, capture_input_filter};
        `PCAP_OFF_VALSEL:   s_axi_rdata_o <= {24'h00_0000, capture_value_select};
        `PCAP_OFF_TRIGSRC:  s_axi_rdata_o <= {24'h00_0000, trigger_source_select};
        `PCAP_OFF_TRIGEDGE: s_axi_rdata_o <= {24'h00_0000, trigger_edge_select};
        `PCAP_OFF_PREEDGE:  s_axi_rdata_o <= {24'h00_0000, precondition_edge_select};
        `PCAP_OFF_PRESRC:   s_axi_rdata_o <= {24'h00_0000, precondition_source_select};
        `PCAP_OFF_POS_LO:   s_axi_rdata_o <= captured_position[31:0];
        `PCAP_OFF_POS_HI:   s_axi_rdata_o <= captured_position[63:32];
        `PCAP_OFF_TIME:     s_axi_rdata_o <= captured_time;
        default:            s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // configuration registers; out-of-range writes are ignored
  assign arm_wr = wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_CTRL);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      precondition_event_mode    <= `PCAP_RST_EVENT;
      capture_input_filter       <= `PCAP_RST_FILTER;
      capture_value_select       <= `PCAP_RST_VALSEL;
      trigger_source_select      <= `PCAP_RST_TRIGSRC;
      trigger_edge_select        <= `PCAP_RST_TRIGEDGE;
      precondition_edge_select   <= `PCAP_RST_PREEDGE;
      precondition_source_select <= `PCAP_RST_PRESRC;
    end else begin
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_EVENT) &&
          w_data[7:0] <= `PCAP_MAX_EVENT) begin
        precondition_event_mode <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_FILTER) &&
          w_data[7:0] <= `PCAP_MAX_FILTER) begin
        capture_input_filter <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_TRIGSRC) &&
          w_data[7:0] <= `PCAP_MAX_TRIGSRC) begin
        trigger_source_select <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_TRIGEDGE) &&
          w_data[7:0] != 8'h00 && w_data[7:0] <= `PCAP_MAX_EDGE) begin
        trigger_edge_select <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_PREEDGE) &&
          w_data[7:0] != 8'h00 && w_data[7:0] <= `PCAP_MAX_EDGE) begin
        precondition_edge_select <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_PRESRC) &&
          w_data[7:0] <= `PCAP_MAX_PRESRC) begin
        precondition_source_select <= w_data[7:0];
      end
      if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_VALSEL) &&
          w_data[7:0] <= `PCAP_MAX_VALSEL) begin
        capture_value_select <= w_data[7:0];
        if (w_data[2:0] == pcap_pkg::pcap_val_index) begin
          trigger_source_select   <= `PCAP_IDX_PRIMARY;
          trigger_edge_select     <= `PCAP_EDGE_RISE;
          precondition_event_mode <= 8'h00;
        end
      end
    end
  end

  // input synchronisers, two flip-flops per line
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_meta <= 12'h000;
      line_sync <= 12'h000;
      line_prev <= 12'h000;
    end else begin
      line_meta <= {index_tertiary_i, index_primary_i, rs485_in_i, gen_in_i};
      line_sync <= line_meta;
      line_prev <= line_sync;
    end
  end

  // source selection and edge detection
  assign trig_edge = edge_hit(sel_line(line_sync, trigger_source_select, `PCAP_MAX_TRIGSRC),
                              sel_line(line_prev, trigger_source_select, `PCAP_MAX_TRIGSRC),
                              trigger_edge_select);
  assign pre_edge  = edge_hit(sel_line(line_sync, precondition_source_select, `PCAP_MAX_PRESRC),
                              sel_line(line_prev, precondition_source_select, `PCAP_MAX_PRESRC),
                              precondition_edge_select);
  assign pre_level = sel_line(line_sync, precondition_source_select, `PCAP_MAX_PRESRC);

  always_comb begin
    case (precondition_event_mode[1:0])
      pcap_pkg::pcap_ev_ignore: qualify = 1'b1;
      pcap_pkg::pcap_ev_after:  qualify = (state == pcap_pkg::pcap_primed) && !pre_edge;
      pcap_pkg::pcap_ev_high:   qualify = pre_level;
      pcap_pkg::pcap_ev_low:    qualify = !pre_level;
      default:                  qualify = 1'b0;
    endcase
  end

  assign cap_fire   = (state != pcap_pkg::pcap_idle) && trig_edge && qualify &&
                      (capture_value_select[2:0] != pcap_pkg::pcap_val_rsvd);
  assign auto_rearm = (capture_value_select[2:0] == pcap_pkg::pcap_val_index) ||
                      (capture_value_select[2:0] == pcap_pkg::pcap_val_auto);

  // arm state: idle, armed, primed by precondition edge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= pcap_pkg::pcap_idle;
    end else if (arm_wr) begin
      state <= w_data[0] ? pcap_pkg::pcap_armed : pcap_pkg::pcap_idle;
    end else if (wr_hit(do_wr, aw_addr, w_strb, `PCAP_OFF_VALSEL) &&
                 w_data[7:0] == {5'h00, pcap_pkg::pcap_val_index}) begin
      state <= pcap_pkg::pcap_armed;
    end else begin
      case (state)
        pcap_pkg::pcap_idle: state <= pcap_pkg::pcap_idle;
        pcap_pkg::pcap_armed: begin
          if (cap_fire) begin
            state <= auto_rearm ? pcap_pkg::pcap_armed : pcap_pkg::pcap_idle;
          end else if (pre_edge &&
                       precondition_event_mode[1:0] == pcap_pkg::pcap_ev_after) begin
            state <= pcap_pkg::pcap_primed;
          end
        end
        pcap_pkg::pcap_primed: begin
          if (cap_fire) begin
            state <= auto_rearm ? pcap_pkg::pcap_armed : pcap_pkg::pcap_idle;
          end else if (precondition_event_mode[1:0] != pcap_pkg::pcap_ev_after) begin
            state <= pcap_pkg::pcap_armed;
          end
        end
        default: state <= pcap_pkg::pcap_idle;
      endcase
    end
  end

  // drive-internal time since the last reference sync
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      time_ns <= 32'h0000_0000;
    end else if (time_ref_sync_i) begin
      time_ns <= 32'h0000_0000;
    end else begin
      time_ns <= time_ns + `PCAP_NS_PER_CLK;
    end
  end

  // captured values
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      captured_position <= 64'sh0000_0000_0000_0000;
    end else if (cap_fire && capture_value_select[2:0] != pcap_pkg::pcap_val_time) begin
      captured_position <= position_feedback_i;
    end else if (arm_wr && w_data[0]) begin
      captured_position <= 64'sh0000_0000_0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      captured_time <= 32'h0000_0000;
    end else if (cap_fire && capture_value_select[2:0] == pcap_pkg::pcap_val_time) begin
      captured_time <= time_ns;
    end
  end

  // captured flag, set wins over the clear by enabling
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      captured_flag <= 1'b0;
    end else if (cap_fire) begin
      captured_flag <= 1'b1;
    end else if (arm_wr && w_data[0]) begin
      captured_flag <= 1'b0;
    end
  end

  assign captured_flag_o = captured_flag;

  // checks
  property p_mode0_capture;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state != pcap_pkg::pcap_idle && precondition_event_mode == 8'h00 && trig_edge &&
     capture_value_select[2:0] != pcap_pkg::pcap_val_rsvd) |-> cap_fire;
  endproperty
  a_mode0_capture: assert property (p_mode0_capture)
    else $error("mode 0 trigger edge not captured");

  property p_after_edge;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && precondition_event_mode == 8'h01) |->
      (state == pcap_pkg::pcap_primed) && $past(state) != pcap_pkg::pcap_idle;
  endproperty
  a_after_edge: assert property (p_after_edge)
    else $error("mode 1 capture without prior precondition edge");

  property p_same_tick;
    @(posedge ref_clk_i) disable iff (rst_i)
    (precondition_event_mode == 8'h01 && pre_edge) |-> !cap_fire;
  endproperty
  a_same_tick: assert property (p_same_tick)
    else $error("coincident precondition and trigger edge captured");

  property p_level_high;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && precondition_event_mode == 8'h02) |-> pre_level;
  endproperty
  a_level_high: assert property (p_level_high)
    else $error("mode 2 capture with precondition low");

  property p_level_low;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && precondition_event_mode == 8'h03) |-> !pre_level;
  endproperty
  a_level_low: assert property (p_level_low)
    else $error("mode 3 capture with precondition high");

  property p_pos_latch;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && capture_value_select[2:0] == pcap_pkg::pcap_val_pos) |=>
      captured_position == $past(position_feedback_i) && captured_flag;
  endproperty
  a_pos_latch: assert property (p_pos_latch)
    else $error("position not latched on capture");

  property p_time_latch;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && capture_value_select[2:0] == pcap_pkg::pcap_val_time) |=>
      captured_time == $past(time_ns);
  endproperty
  a_time_latch: assert property (p_time_latch)
    else $error("time not latched on capture");

  property p_disarm;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && !auto_rearm && !do_wr) |=> state == pcap_pkg::pcap_idle;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("engine still enabled after single capture");

  property p_rearm;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cap_fire && auto_rearm && !do_wr) |=> state == pcap_pkg::pcap_armed;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("auto mode did not re-arm");

  property p_reserved;
    @(posedge ref_clk_i) disable iff (rst_i)
    (capture_value_select[2:0] == pcap_pkg::pcap_val_rsvd) |-> !cap_fire;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("capture in reserved value mode");

  property p_edge_only;
    @(posedge ref_clk_i) disable iff (rst_i)
    cap_fire |-> trig_edge;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("capture without trigger edge");

  property p_enable_clears;
    @(posedge ref_clk_i) disable iff (rst_i)
    (arm_wr && w_data[0] && !cap_fire) |=> !captured_flag && captured_position == 64'sh0;
  endproperty
  a_enable_clears: assert property (p_enable_clears)
    else $error("enable did not clear flag and position");

endmodule // pcap_engine

// [bench/pcap_pins_model.sv]
// level model of the pins that feed the capture engine
`timescale 1ns/1ps
module pcap_pins_model (
  input  wire logic [11:0] lvl_i,
  output logic [6:0]       gen_o,
  output logic [2:0]       rs485_o,
  output logic             idx_p_o,
  output logic             idx_t_o
);
  // bit n of lvl_i is source code n
  assign {idx_t_o, idx_p_o, rs485_o, gen_o} = lvl_i;
endmodule // pcap_pins_model

// [bench/pcap_engine_tb.sv]
// self-checking bench of the capture engine
`timescale 1ns/1ps
module pcap_engine_tb;
  logic        ref_clk_i, rst_i, awv, wv, brdy, arv, rrdy, flag, awr, wr_r, bv, arr, rvl, tsync;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, lfsr, rv;
  logic [1:0]  br, rr, rrs, wb;
  logic [11:0] lvl;
  logic [6:0]  gen;
  logic [2:0]  rs;
  logic        ip, it;
  logic [63:0] pos, ep;
  int          n_fail, num_checks, k, e;
  pcap_pins_model i_pcap_pins_model (.lvl_i(lvl), .gen_o(gen), .rs485_o(rs), .idx_p_o(ip),
    .idx_t_o(it));
  pcap_engine i_pcap_engine (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .gen_in_i(gen),
    .rs485_in_i(rs), .index_primary_i(ip), .index_tertiary_i(it), .position_feedback_i(pos),
    .time_ref_sync_i(tsync), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rvl), .s_axi_rready_i(rrdy), .captured_flag_o(flag));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic sa, sw, sb;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1; sb = 1'b0;
    for (k = 0; k < 40 && !sb; k++) begin
      @(negedge ref_clk_i); sa = awr; sw = wr_r; sb = bv; wb = br;
      @(posedge ref_clk_i);
      if (sa) awv <= 1'b0;
      if (sw) wv <= 1'b0;
    end
    brdy <= 1'b0;
    if (!sb) begin n_fail++; finish_test; end
    @(posedge ref_clk_i);
  endtask
  task rd(input logic [7:0] a);
    logic sa, sr;
    ara <= a; arv <= 1'b1; rrdy <= 1'b1; sr = 1'b0;
    for (k = 0; k < 40 && !sr; k++) begin
      @(negedge ref_clk_i); sa = arr; sr = rvl; rv = rdat; rr = rrs;
      @(posedge ref_clk_i);
      if (sa) arv <= 1'b0;
    end
    rrdy <= 1'b0;
    if (!sr) begin n_fail++; finish_test; end
    @(posedge ref_clk_i);
  endtask
  task pin(input int n, input logic v);
    lvl[n] <= v;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task fl(input logic x);
    rd(8'h04); chk({63'h0, rv[0]}, {63'h0, x});
    chk({63'h0, flag}, {63'h0, x});
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_fail++;
    finish_test;
  end
  initial begin
    rst_i = 1'b1; awv = 1'b0; wv = 1'b0; brdy = 1'b0; arv = 1'b0; rrdy = 1'b0; tsync = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0000_0000; lvl = 12'h000; lfsr = 32'h0000_0026;
    pos = 64'h0000_0000_0000_0000; n_fail = 0; num_checks = 0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(8'h08); chk(rv, 32'h0000_0000);
    rd(8'h18); chk(rv, 32'h0000_0001);
    rd(8'h1C); chk(rv, 32'h0000_0001);
    rd(8'h24); chk(rv, 32'h0000_0000);
    rd(8'h30); chk(rr, 2'h2);
    wr(8'h30, 32'h0000_0000); chk(wb, 2'h2);
    for (e = 0; e < 12; e++) begin
      lfsr = nxt(lfsr); ep = {~lfsr, lfsr}; pos <= ep;
      wr(8'h14, e); wr(8'h00, 32'h0000_0001); fl(1'b0);
      pin(e, 1'b1); fl(1'b1);
      rd(8'h24); chk(rv, ep[31:0]);
      rd(8'h28); chk(rv, ep[63:32]);
      rd(8'h00); chk(rv, 32'h0000_0000);
      pin(e, 1'b0);
    end
    wr(8'h14, 32'h0000_0000); chk(wb, 2'h0);
    for (e = 1; e < 4; e++) begin
      wr(8'h18, e); wr(8'h00, 32'h0000_0001); pin(0, 1'b1); fl(e != 2);
      wr(8'h00, 32'h0000_0001); pin(0, 1'b0); fl(e != 1);
    end
    wr(8'h18, 32'h0000_0001); wr(8'h20, 32'h0000_0003);
    for (e = 2; e < 4; e++) begin
      wr(8'h08, e); wr(8'h00, 32'h0000_0001); pin(0, 1'b1); fl(e == 3);
      pin(0, 1'b0); pin(3, 1'b1); wr(8'h00, 32'h0000_0001);
      pin(0, 1'b1); fl(e == 2);
      pin(0, 1'b0); pin(3, 1'b0);
    end
    wr(8'h08, 32'h0000_0001); wr(8'h00, 32'h0000_0001);
    pin(0, 1'b1); fl(1'b0); pin(0, 1'b0);
    lvl[3] <= 1'b1; pin(0, 1'b1); fl(1'b0);
    lvl[3] <= 1'b0; pin(0, 1'b0); pin(0, 1'b1); fl(1'b1);
    wr(8'h1C, 32'h0000_0002); wr(8'h00, 32'h0000_0001);
    pin(3, 1'b1); pin(0, 1'b0); pin(0, 1'b1); fl(1'b0);
    pin(3, 1'b0); pin(0, 1'b0); pin(0, 1'b1); fl(1'b1);
    pin(0, 1'b0); wr(8'h08, 32'h0000_0000); wr(8'h10, 32'h0000_0004);
    wr(8'h00, 32'h0000_0001); pin(0, 1'b1); fl(1'b1);
    rd(8'h00); chk(rv, 32'h0000_0001);
    pin(0, 1'b0); wr(8'h10, 32'h0000_0002); wr(8'h00, 32'h0000_0001);
    pin(0, 1'b1); fl(1'b0); pin(0, 1'b0);
    wr(8'h10, 32'h0000_0001); wr(8'h00, 32'h0000_0001);
    tsync <= 1'b1; lvl[0] <= 1'b1; @(posedge ref_clk_i); tsync <= 1'b0;
    repeat (5) @(posedge ref_clk_i); fl(1'b1);
    rd(8'h2C); chk(rv, 32'h0000_0014);
    rd(8'h24); chk(rv, 32'h0000_0000);
    pin(0, 1'b0);
    wr(8'h10, 32'h0000_0003);
    rd(8'h14); chk(rv, 32'h0000_000A);
    rd(8'h08); chk(rv, 32'h0000_0000);
    rd(8'h00); chk(rv, 32'h0000_0001);
    pin(10, 1'b1); fl(1'b1);
    rd(8'h24); chk(rv, ep[31:0]);
    rd(8'h00); chk(rv, 32'h0000_0001);
    finish_test;
  end
endmodule // pcap_engine_tb
